// ### hw/modem_port.sv
`timescale 1ns/1ns
module modem_port (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             response_err,
    input  wire logic        carrier_n,
    input  wire logic        ring_n,
    input  wire logic        set_ready_n,
    input  wire logic        clear_send_n,
    output logic             terminal_ready_n,
    output logic             send_request_n,
    output logic             user_output_one_n,
    output logic             user_output_two_n,
    output logic             baud_tick,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]  interrupt_enable_reg;
        logic [7:0]  fifo_control_reg;
        logic [7:0]  line_control_reg;
        logic [7:0]  modem_control_reg;
        logic [7:0]  line_status_reg;
        logic [7:0]  interrupt_ident_reg;
        logic [7:0]  scratch;
        logic [7:0]  divisor_low_byte;
        logic [7:0]  divisor_high_byte;
        logic [3:0]  change_flags;
        logic [3:0]  irq_status;
        logic [3:0]  irq_mask;
        logic [31:0] readdata;
        logic        done;
        logic        err;
        logic        irq;
        logic        baud_tick;
        logic [3:0]  line_out_n;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;

    logic [3:0] status_level;
    logic [3:0] level_changed;
    logic       div_tick;
    logic       access;
    logic [3:0] index;
    logic       in_range;

    // ------------------------------------------------------------
    // Write a byte honouring byte lane zero
    // ------------------------------------------------------------
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] be);
        lane0 = be[0] ? wd[7:0] : old;
    endfunction

    // ------------------------------------------------------------
    // Current line state, with loopback substitution
    // ------------------------------------------------------------
    always_comb begin
        if (state.modem_control_reg[modem_port_pkg::MCR_LOOP]) begin
            status_level[3] = state.modem_control_reg[modem_port_pkg::MCR_USER_OUTPUT_TWO];
            status_level[2] = state.modem_control_reg[modem_port_pkg::MCR_USER_OUTPUT_ONE];
            status_level[1] = state.modem_control_reg[modem_port_pkg::MCR_DTR];
            status_level[0] = state.modem_control_reg[modem_port_pkg::MCR_RTS];
        end else begin
            status_level[3] = ~carrier_n;
            status_level[2] = ~ring_n;
            status_level[1] = ~set_ready_n;
            status_level[0] = ~clear_send_n;
        end
    end

    // Change detection runs on the looped value, so loopback tests see deltas;
    // the ring flag wants the falling level, so the rising report stays unused
    edge_flagger #(
        .WIDTH (4)
    ) u_edges (
        .clock   (clock),
        .arst_n  (arst_n),
        .level   (status_level),
        .changed (level_changed),
        .rose    ()
    );

    baud_divider #(
        .DIV (modem_port_pkg::BAUD_DIV)
    ) u_baud (
        .clock  (clock),
        .arst_n (arst_n),
        .tick   (div_tick)
    );

    assign access   = (read || write) && !state.done;
    assign index    = address[5:2];
    assign in_range = (address[1:0] == 2'h0) && (index <= modem_port_pkg::IDX_IRQ_MASK);

    // ------------------------------------------------------------
    // Bus slave, registers and flags; one wait cycle per access
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] events;
        logic [3:0] flags_set;
        logic       stat_read;
        events    = '0;
        flags_set = '0;
        stat_read = 1'b0;
        next_state           = state;
        next_state.done      = access;
        next_state.err       = 1'b0;
        next_state.baud_tick = div_tick;

        // Change flags: ring counts only its trailing edge, ring_n going back high
        // carrier change
        flags_set[modem_port_pkg::MS_DDCD] = level_changed[3];
        flags_set[modem_port_pkg::MS_RING_TRAILING_EDGE_FLAG] = level_changed[2] & ~status_level[2];
        flags_set[modem_port_pkg::MS_SET_READY_CHANGE_FLAG] = level_changed[1];
        flags_set[modem_port_pkg::MS_DCTS] = level_changed[0];

        if (access && read && in_range) begin
            next_state.readdata = '0;
            case (index)
                4'(modem_port_pkg::IDX_RX_TX): begin
                    next_state.readdata[7:0] = state.line_control_reg[modem_port_pkg::LCR_DLAB]
                                               ? state.divisor_low_byte : modem_port_pkg::RST_ZERO;
                end
                4'(modem_port_pkg::IDX_INT_ENABLE): begin
                    next_state.readdata[7:0] = state.line_control_reg[modem_port_pkg::LCR_DLAB]
                                               ? state.divisor_high_byte : state.interrupt_enable_reg;
                end
                4'(modem_port_pkg::IDX_IDENT_FIFO): next_state.readdata[7:0] = state.interrupt_ident_reg;
                4'(modem_port_pkg::IDX_LINE_CTRL):  next_state.readdata[7:0] = state.line_control_reg;
                4'(modem_port_pkg::IDX_MODEM_CTRL): next_state.readdata[7:0] = state.modem_control_reg;
                4'(modem_port_pkg::IDX_LINE_STAT):  next_state.readdata[7:0] = state.line_status_reg;
                4'(modem_port_pkg::IDX_MODEM_STAT): begin
                    next_state.readdata[7:0] = {status_level, state.change_flags};
                    stat_read = 1'b1;
                end
                4'(modem_port_pkg::IDX_SCRATCH):    next_state.readdata[7:0] = state.scratch;
                modem_port_pkg::IDX_IRQ_STATUS:     next_state.readdata[3:0] = state.irq_status;
                modem_port_pkg::IDX_IRQ_MASK:       next_state.readdata[3:0] = state.irq_mask;
                default:                            next_state.readdata = '0;
            endcase
        end else if (access && read) begin
            next_state.readdata = '0;
            next_state.err      = 1'b1;
        end

        if (access && write && in_range) begin
            case (index)
                4'(modem_port_pkg::IDX_RX_TX): begin
                    if (state.line_control_reg[modem_port_pkg::LCR_DLAB]) begin
                        next_state.divisor_low_byte = lane0(state.divisor_low_byte, writedata, byteenable);
                    end
                end
                4'(modem_port_pkg::IDX_INT_ENABLE): begin
                    if (state.line_control_reg[modem_port_pkg::LCR_DLAB]) begin
                        next_state.divisor_high_byte = lane0(state.divisor_high_byte, writedata, byteenable);
                    end else begin
                        next_state.interrupt_enable_reg = lane0(state.interrupt_enable_reg, writedata, byteenable);
                    end
                end
                4'(modem_port_pkg::IDX_IDENT_FIFO): begin
                    next_state.fifo_control_reg = lane0(state.fifo_control_reg, writedata, byteenable);
                end
                4'(modem_port_pkg::IDX_LINE_CTRL): begin
                    next_state.line_control_reg = lane0(state.line_control_reg, writedata, byteenable);
                end
                4'(modem_port_pkg::IDX_MODEM_CTRL): begin
                    next_state.modem_control_reg = lane0(state.modem_control_reg, writedata, byteenable);
                end
                4'(modem_port_pkg::IDX_SCRATCH): begin
                    next_state.scratch = lane0(state.scratch, writedata, byteenable);
                end
                modem_port_pkg::IDX_IRQ_MASK: begin
                    if (byteenable[0]) begin
                        next_state.irq_mask = writedata[3:0];
                    end
                end
                modem_port_pkg::IDX_IRQ_STATUS: begin
                    // Write one to clear
                    if (byteenable[0]) begin
                        events = writedata[3:0];
                    end
                end
                default: begin
                end
            endcase
        end else if (access && write) begin
            next_state.err = 1'b1;
        end

        next_state.change_flags = (stat_read ? 4'h0 : state.change_flags) | flags_set;
        // Sticky interrupt status from the same events; set beats clear
        next_state.irq_status   = (state.irq_status & ~events) | flags_set;
        next_state.irq          = |(next_state.irq_status & next_state.irq_mask);

        // Modem control lines leave the pins inactive (high) in loopback
        next_state.line_out_n = ~(next_state.modem_control_reg[modem_port_pkg::MCR_USER_OUTPUT_TWO:modem_port_pkg::MCR_DTR]
                                  & {4{~next_state.modem_control_reg[modem_port_pkg::MCR_LOOP]}});
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            state.interrupt_enable_reg <= modem_port_pkg::RST_ZERO;
            state.fifo_control_reg     <= modem_port_pkg::RST_ZERO;
            state.line_control_reg     <= modem_port_pkg::RST_ZERO;
            state.modem_control_reg    <= modem_port_pkg::RST_ZERO;
            state.interrupt_ident_reg  <= modem_port_pkg::RST_IDENT;
            state.line_status_reg      <= modem_port_pkg::RST_LINE_STAT;
            state.line_out_n           <= 4'hf;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign readdata          = state.readdata;
    assign waitrequest       = !state.done;
    assign response_err      = state.err;
    assign terminal_ready_n  = state.line_out_n[0];
    assign send_request_n    = state.line_out_n[1];
    assign user_output_one_n = state.line_out_n[2];
    assign user_output_two_n = state.line_out_n[3];
    assign baud_tick         = state.baud_tick;
    assign irq               = state.irq;
endmodule

// ### hw/modem_port_pkg.sv
package modem_port_pkg;

    // ------------------------------------------------------------
    // Register map (printed offsets are not multiples of four, so
    // each offset is an index and the byte address is four times it)
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_RX_TX      = 3'h0;
    localparam logic [2:0] IDX_INT_ENABLE = 3'h1;
    localparam logic [2:0] IDX_IDENT_FIFO = 3'h2;
    localparam logic [2:0] IDX_LINE_CTRL  = 3'h3;
    localparam logic [2:0] IDX_MODEM_CTRL = 3'h4;
    localparam logic [2:0] IDX_LINE_STAT  = 3'h5;
    localparam logic [2:0] IDX_MODEM_STAT = 3'h6;
    localparam logic [2:0] IDX_SCRATCH    = 3'h7;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
    localparam logic [3:0] IDX_IRQ_MASK   = 4'h9;
    localparam int         ADDR_W         = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_IDENT      = 8'h01;
    localparam logic [7:0] RST_LINE_STAT  = 8'h60;
    localparam logic [7:0] RST_MODEM_STAT = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MCR_DTR   = 0;
    localparam int MCR_RTS   = 1;
    localparam int MCR_USER_OUTPUT_ONE  = 2;
    localparam int MCR_USER_OUTPUT_TWO  = 3;
    localparam int MCR_LOOP  = 4;
    localparam int LCR_DLAB  = 7;
    localparam int MS_CTS    = 4;
    localparam int MS_DSR    = 5;
    localparam int MS_RI     = 6;
    localparam int MS_DCD    = 7;
    localparam int MS_DCTS   = 0;
    localparam int MS_SET_READY_CHANGE_FLAG   = 1;
    localparam int MS_RING_TRAILING_EDGE_FLAG   = 2;
    localparam int MS_DDCD   = 3;
    localparam int IRQ_BITS  = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RESET_MIN_NS = 500;
    localparam int BAUD_IN_MHZ  = 24;
    localparam int BAUD_DIV     = 13;

endpackage

// ### hw/edge_flagger.sv
`timescale 1ns/1ns
// Change detector for the four modem lines; tells rising and any change
module edge_flagger #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] changed,
    output logic      [WIDTH-1:0] rose
);
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic             primed;
    } edge_state_t;

    edge_state_t state;
    edge_state_t next_state;

    // ------------------------------------------------------------
    // Remember last level; first cycle after reset reports nothing
    // ------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_state.prev   = level;
        next_state.primed = 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign changed = state.primed ? (level ^ state.prev) : '0;
    assign rose    = state.primed ? (level & ~state.prev) : '0;
endmodule

// ### hw/baud_divider.sv
`timescale 1ns/1ns
// Divides the reference by a fixed ratio to form the baud reference tick
module baud_divider #(
    parameter int DIV = 13
) (
    input  wire logic clock,
    input  wire logic arst_n,
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          tick;
    } div_state_t;

    div_state_t state;
    div_state_t next_state;

    // ------------------------------------------------------------
    // Count up; one tick each DIV cycles
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (state.count == CW'(DIV - 1)) begin
            next_state.count = '0;
            next_state.tick  = 1'b1;
        end else begin
            next_state.count = state.count + CW'(1);
            next_state.tick  = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule

// ### test/modem_peer.sv
`timescale 1ns/1ns
// Far-side modem: drives the four active-low status lines, idle high
module modem_peer (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic [3:0] want_n,
    output logic            carrier_n,
    output logic            ring_n,
    output logic            set_ready_n,
    output logic            clear_send_n
);
    // Lines follow the command one edge later, like a registered driver
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {carrier_n, ring_n, set_ready_n, clear_send_n} <= 4'hf;
        end else begin
            {carrier_n, ring_n, set_ready_n, clear_send_n} <= want_n;
        end
    end
endmodule

// ### test/modem_port_chk.sv
`timescale 1ns/1ns
// Watches bus answers, modem status reads, modem outputs and baud tick
module modem_port_chk (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic [5:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        response_err,
    input wire logic        carrier_n,
    input wire logic        ring_n,
    input wire logic        set_ready_n,
    input wire logic        clear_send_n,
    input wire logic        terminal_ready_n,
    input wire logic        send_request_n,
    input wire logic        user_output_one_n,
    input wire logic        user_output_two_n,
    input wire logic        baud_tick,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Shadow state taken from accepted writes, line levels and status reads
    // ------------------------------------------------------------
    logic [4:0] mcr_q;
    logic [3:0] mask_q;
    logic [3:0] lvl_q;
    logic [1:0] quiet;
    logic       chg;
    wire        ans   = !waitrequest;
    wire        taken = (read || write) && waitrequest;
    wire        stat  = read && ans && address == 6'h18;
    wire  [3:0] lvl   = mcr_q[4] ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]}
                                 : ~{carrier_n, ring_n, set_ready_n, clear_send_n};
    wire        evt   = quiet != 2'h3 || lvl != lvl_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Quiet counts edges since the level moved; flags may lag a change by a cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mcr_q  <= 5'h00;
            mask_q <= 4'h0;
            lvl_q  <= 4'h0;
            quiet  <= 2'h0;
            chg    <= 1'b0;
        end else begin
            lvl_q <= lvl;
            quiet <= (lvl != lvl_q) ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
            chg   <= stat ? evt : (chg || evt);
            if (write && ans && byteenable[0] && address == 6'h10) begin
                mcr_q <= writedata[4:0];
            end
            if (write && ans && byteenable[0] && address == 6'h24) begin
                mask_q <= writedata[3:0];
            end
        end
    end

    // Bus answers and refusals
    chk_wait_answer: assert property (taken && $past(waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("answer not one cycle after request");
    chk_wait_idle: assert property (!read && !write |=> waitrequest)
        else $error("waitrequest low with no request");
    chk_err_unmapped: assert property (taken && $past(waitrequest) && (address[5:2] > 4'h9 || address[1:0] != 2'h0)
        |=> response_err && (write || readdata == 32'h0)) else $error("unmapped access not refused");
    chk_err_mapped: assert property (taken && $past(waitrequest) && address[5:2] <= 4'h9 && address[1:0] == 2'h0
        |=> !response_err) else $error("mapped access refused");
    // Status lines, change flags and outputs
    chk_status_lines: assert property (stat && quiet == 2'h3 |-> readdata[7:4] == lvl && readdata[31:8] == 24'h0)
        else $error("status levels wrong");
    chk_flags_clear: assert property (stat && !chg |-> readdata[3:0] == 4'h0)
        else $error("change flags set with no change since read");
    // The design applies a write one edge before the shadow copy, so skip that answer edge
    chk_outputs_mcr: assert property ($stable(mcr_q) && !(write && ans && address == 6'h10)
        |-> {user_output_two_n, user_output_one_n, send_request_n, terminal_ready_n}
        == (mcr_q[4] ? 4'hf : ~mcr_q[3:0])) else $error("modem outputs wrong");
    chk_irq_masked: assert property (mask_q == 4'h0 && $stable(mask_q)
        && !(write && ans && address == 6'h24) |-> !irq)
        else $error("irq high with all masked");
    chk_baud_period: assert property (baud_tick |=> (!baud_tick) [*8] ##1 (!baud_tick) [*4] ##1 baud_tick)
        else $error("baud tick period wrong");

    cov_flag_seen: cover property (stat && readdata[3:0] != 4'h0);
    cov_loop_read: cover property (stat && mcr_q[4]);
    cov_irq_rise: cover property ($rose(irq));
    cov_refused: cover property (ans && response_err);
endmodule

bind modem_port modem_port_chk u_chk (.clock(clock), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response_err(response_err), .carrier_n(carrier_n), .ring_n(ring_n),
    .set_ready_n(set_ready_n), .clear_send_n(clear_send_n), .terminal_ready_n(terminal_ready_n),
    .send_request_n(send_request_n), .user_output_one_n(user_output_one_n),
    .user_output_two_n(user_output_two_n), .baud_tick(baud_tick), .irq(irq));

// ### test/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for modem_port
module tb_top;
    logic        clock, arst_n, read, write, response_err, waitrequest, baud_tick, irq;
    logic [5:0]  address;
    logic [31:0] writedata, readdata, q, r;
    logic [3:0]  byteenable, want_n, prev_hi, hi, p, k;
    logic        carrier_n, ring_n, set_ready_n, clear_send_n, e;
    logic        terminal_ready_n, send_request_n, user_output_one_n, user_output_two_n;
    logic [4:0]  cur_mcr, m;
    logic [7:0]  x;
    int          err_count, num_checks, cycles, tk;
    integer      seed;
    wire  [3:0]  outs = {user_output_two_n, user_output_one_n, send_request_n, terminal_ready_n};
    localparam logic [5:0] RADDR [8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24};
    localparam logic [7:0] RVAL  [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00};

    modem_port u_dut (.clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .response_err(response_err), .carrier_n(carrier_n), .ring_n(ring_n), .set_ready_n(set_ready_n),
        .clear_send_n(clear_send_n), .terminal_ready_n(terminal_ready_n), .send_request_n(send_request_n),
        .user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
        .baud_tick(baud_tick), .irq(irq));
    modem_peer u_peer (.clock(clock), .arst_n(arst_n), .want_n(want_n), .carrier_n(carrier_n),
        .ring_n(ring_n), .set_ready_n(set_ready_n), .clear_send_n(clear_send_n));

    // ------------------------------------------------------------
    // Clock, timeout, shared tasks
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Hang guard: a run of this length should never take 4000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic [5:0] a, input logic wr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address   <= a;
        read      <= !wr;
        write     <= wr;
        writedata <= {24'h0, d};
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        q = readdata;
        e = response_err;
        read  <= 1'b0;
        write <= 1'b0;
        cmp("bus answer", 32'h1, {31'h0, n < 40});
    endtask
    function automatic logic [3:0] hi_of(input logic [4:0] mc, input logic [3:0] pn);
        return mc[4] ? {mc[3], mc[2], mc[0], mc[1]} : ~pn;
    endfunction
    function automatic logic [7:0] exp_stat(input logic [3:0] was, input logic [3:0] now);
        return {now, was[3] ^ now[3], was[2] && !now[2], was[1] ^ now[1], was[0] ^ now[0]};
    endfunction
    // Reset held five cycles, i.e. 500 ns at this clock
    // The aligning edge keeps the very first hold from falling short of 500 ns
    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        cur_mcr = 5'h00;
        prev_hi = 4'h0;
    endtask
    task automatic check_reset();
        for (int i = 0; i < 8; i++) begin
            bus(RADDR[i], 1'b0, 8'h00);
            cmp("reset value", {24'h0, RVAL[i]}, q);
        end
        cmp("reset outs", 32'hf, {28'h0, outs});
        bus(6'h14, 1'b1, 8'hff);
        bus(6'h14, 1'b0, 8'h00);
        cmp("line status read only", 32'h60, q);
        bus(6'h28, 1'b0, 8'h00);
        cmp("unmapped err", 32'h1, {31'h0, e});
        cmp("unmapped data", 32'h0, q);
        bus(6'h19, 1'b1, 8'h5a);
        cmp("misaligned err", 32'h1, {31'h0, e});
    endtask

    initial begin
        arst_n = 1'b0; address = 6'h00; read = 1'b0; write = 1'b0; writedata = 32'h0;
        byteenable = 4'hf; want_n = 4'hf; seed = 13167; err_count = 0; num_checks = 0; cycles = 0;
        do_reset();
        check_reset();
        $display("test reset_values done");
        // Software reset order: line ctrl, divisor bytes, modem ctrl, flush reads, enable last
        r = $random(seed);
        bus(6'h0c, 1'b1, 8'h80);
        bus(6'h00, 1'b1, r[7:0]);
        bus(6'h04, 1'b1, r[15:8]);
        bus(6'h00, 1'b0, 8'h00);
        cmp("divisor low", {24'h0, r[7:0]}, q);
        bus(6'h04, 1'b0, 8'h00);
        cmp("divisor high", {24'h0, r[15:8]}, q);
        bus(6'h0c, 1'b1, 8'h03);
        bus(6'h10, 1'b1, 8'h00);
        bus(6'h14, 1'b0, 8'h00);
        cmp("line status", 32'h60, q);
        bus(6'h00, 1'b0, 8'h00);
        cmp("receive buffer", 32'h0, q);
        bus(6'h04, 1'b1, 8'h00);
        tk = 0;
        repeat (130) begin
            @(posedge clock);
            if (baud_tick === 1'b1) tk++;
        end
        cmp("baud ticks", 32'd10, tk);
        $display("test program_and_baud done");
        // Random lines, modem control, loopback and mask; ordered so a level moves once
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            m = r[4:0];
            p = r[11:8];
            k = r[19:16];
            bus(6'h24, 1'b1, {4'h0, k});
            if (cur_mcr[4]) begin
                want_n <= p;
                bus(6'h10, 1'b1, {3'h0, m});
            end else begin
                bus(6'h10, 1'b1, {3'h0, m});
                want_n <= p;
            end
            repeat (4) @(posedge clock);
            hi = hi_of(m, p);
            x  = exp_stat(prev_hi, hi);
            cmp("irq", {31'h0, |(x[3:0] & k)}, {31'h0, irq});
            cmp("modem outs", {28'h0, m[4] ? 4'hf : ~m[3:0]}, {28'h0, outs});
            bus(6'h18, 1'b0, 8'h00);
            cmp("status", {24'h0, x}, q);
            bus(6'h20, 1'b0, 8'h00);
            cmp("irq status", {28'h0, x[3:0]}, q);
            bus(6'h18, 1'b0, 8'h00);
            cmp("status reread", {24'h0, hi, 4'h0}, q);
            bus(6'h20, 1'b1, 8'h0f);
            repeat (2) @(posedge clock);
            cmp("irq cleared", 32'h0, {31'h0, irq});
            prev_hi = hi;
            cur_mcr = m;
        end
        $display("test modem_status_random done");
        want_n <= 4'hf;
        repeat (3) @(posedge clock);
        do_reset();
        check_reset();
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule
